// [rtl/tt2_pkg.sv]
// constants, register map and mode encoding for the timer two core
package tt2_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;

   // register addresses
   localparam logic [7:0] CTRL_ADDR     = 8'hC8;
   localparam logic [7:0] MODE_ADDR     = 8'hC9;
   localparam logic [7:0] CNT_LOW_ADDR  = 8'hCA;
   localparam logic [7:0] CNT_HIGH_ADDR = 8'hCB;
   localparam logic [7:0] CAP_LOW_ADDR  = 8'hCC;
   localparam logic [7:0] CAP_HIGH_ADDR = 8'hCD;

   // control register fields, and the down count enable bit of the mode register
   localparam int OVF_FLAG_BIT  = 7;
   localparam int EXT_FLAG_BIT  = 6;
   localparam int RX_SEL_BIT    = 5;
   localparam int TX_SEL_BIT    = 4;
   localparam int EXT_EN_BIT    = 3;
   localparam int RUN_BIT       = 2;
   localparam int CNT_SEL_BIT   = 1;
   localparam int CAP_SEL_BIT   = 0;
   localparam int DOWN_EN_BIT   = 0;

   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [7:0] BYTE_ZERO  = 8'h00;
   localparam logic [7:0] BIT_ONE    = 8'h01;

   // machine cycle of twelve oscillator periods, S1P1 is phase 0
   localparam logic [3:0] PHASE_ZERO   = 4'h0;
   localparam logic [3:0] PHASE_ONE    = 4'h1;
   localparam logic [3:0] PHASE_LAST   = 4'hB;
   localparam logic [3:0] SAMPLE_PHASE = 4'h9;
   localparam logic [3:0] UPDATE_PHASE = 4'h4;

   localparam logic [15:0] COUNT_MAX  = 16'hFFFF;
   localparam logic [15:0] COUNT_ZERO = 16'h0000;
   localparam logic [15:0] COUNT_ONE  = 16'h0001;
   localparam logic [1:0]  EDGE_FALL  = 2'h2;
   localparam logic [1:0]  HIST_RESET = 2'h0;
   localparam logic [1:0]  SER_MODE1  = 2'h1;
   localparam logic [1:0]  SER_MODE3  = 2'h3;

   typedef enum logic [3:0] {
      TT2_OFF     = 4'b0001,
      TT2_RELOAD  = 4'b0010,
      TT2_CAPTURE = 4'b0100,
      TT2_BAUD    = 4'b1000
   } tt2_mode_e;

endpackage

// [rtl/tt2_phase_sampler.sv]
// machine cycle phase counter and per-cycle pin edge sampler
module tt2_phase_sampler (
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       rst_b,
   // pins
   input  wire logic       countPin,
   input  wire logic       trigPin,
   // phase and edge outputs
   output logic [3:0]      phase,
   output logic            stateTick,
   output logic            updateTick,
   output logic            countEdge,
   output logic            trigEdge,
   output logic            trigLevel
);

   logic [3:0] phase_q;
   logic [1:0] countHist_q;
   logic [1:0] trigHist_q;

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         phase_q <= tt2_pkg::PHASE_ZERO;
      end else if (phase_q == tt2_pkg::PHASE_LAST) begin
         phase_q <= tt2_pkg::PHASE_ZERO;
      end else begin
         phase_q <= phase_q + tt2_pkg::PHASE_ONE;
      end
   end

   // one sample per machine cycle, the older sample kept beside it
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         countHist_q <= tt2_pkg::HIST_RESET;
         trigHist_q  <= tt2_pkg::HIST_RESET;
      end else if (phase_q == tt2_pkg::SAMPLE_PHASE) begin
         countHist_q <= {countHist_q[0], countPin};
         trigHist_q  <= {trigHist_q[0], trigPin};
      end
   end

   assign phase      = phase_q;
   assign stateTick  = phase_q[0];
   assign updateTick = (phase_q == tt2_pkg::UPDATE_PHASE);
   // the update phase falls once between samples, so each pair counts once
   assign countEdge  = updateTick && (countHist_q == tt2_pkg::EDGE_FALL);
   assign trigEdge   = updateTick && (trigHist_q == tt2_pkg::EDGE_FALL);
   assign trigLevel  = trigHist_q[0];

endmodule

// [rtl/tt2_core.sv]
// sixteen-bit timer two with capture, auto-reload and baud clock modes
module tt2_core (
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       rst_b,
   // register port
   input  wire logic [7:0] regAddr,
   input  wire logic [7:0] regWrData,
   input  wire logic       regWr,
   input  wire logic       regRd,
   output logic [7:0]      regRdData,
   // bit access to the control register
   input  wire logic       bitWr,
   input  wire logic [2:0] bitIndex,
   input  wire logic       bitValue,
   // external pins
   input  wire logic       countPin,
   input  wire logic       trigPin,
   // system side
   input  wire logic       timerIntEnable,
   input  wire logic [1:0] serialMode,
   input  wire logic       otherTimerOvf,
   output logic            timerIrq,
   output logic            rxClkPulse,
   output logic            txClkPulse,
   output logic            overflowPulse
);

   // control and mode registers
   logic [7:0]  ctrl_q;
   logic [7:0]  ctrl_d;
   logic        downEn_q;
   logic        downEn_d;

   // count and capture pairs
   logic [7:0]  countLow_q;
   logic [7:0]  countHigh_q;
   logic [7:0]  capLow_q;
   logic [7:0]  capHigh_q;
   logic [15:0] count_d;
   logic [15:0] cap_d;

   // registered outputs
   logic [7:0]  rdData_q;
   logic        irq_q;
   logic        rxClk_q;
   logic        txClk_q;
   logic        ovfPulse_q;

   // sampler outputs; the raw phase is left open, only its ticks, edges and trigger level are used
   logic        stateTick;
   logic        updateTick;
   logic        countEdge;
   logic        trigEdge;
   logic        trigLevel;

   // decoded control
   tt2_pkg::tt2_mode_e mode;
   logic        serialUse;
   logic        countTick;
   logic        wrapEvent;
   logic        flagOverflow;
   logic        extSet;
   logic        extToggle;
   logic [15:0] count;
   logic [15:0] capture;
   logic [7:0]  wrMask;
   logic [7:0]  wrVal;

   function automatic logic serialSelected(input logic [7:0] c);
      serialSelected = c[tt2_pkg::RX_SEL_BIT] | c[tt2_pkg::TX_SEL_BIT];
   endfunction

   function automatic tt2_pkg::tt2_mode_e decodeMode(input logic [7:0] c);
      if (!c[tt2_pkg::RUN_BIT]) begin
         decodeMode = tt2_pkg::TT2_OFF;
      end else if (serialSelected(c)) begin
         decodeMode = tt2_pkg::TT2_BAUD;
      end else if (c[tt2_pkg::CAP_SEL_BIT]) begin
         decodeMode = tt2_pkg::TT2_CAPTURE;
      end else begin
         decodeMode = tt2_pkg::TT2_RELOAD;
      end
   endfunction

   tt2_phase_sampler u_sampler (
      .mclk       (mclk),
      .rst_b      (rst_b),
      .countPin   (countPin),
      .trigPin    (trigPin),
      .phase      (),
      .stateTick  (stateTick),
      .updateTick (updateTick),
      .countEdge  (countEdge),
      .trigEdge   (trigEdge),
      .trigLevel  (trigLevel)
   );

   assign count     = {countHigh_q, countLow_q};
   assign capture   = {capHigh_q, capLow_q};
   assign mode      = decodeMode(ctrl_q);
   assign serialUse = serialSelected(ctrl_q);

   // count source; baud mode in timer function runs at the state rate
   always_comb begin
      countTick = 1'b0;
      case (mode)
         tt2_pkg::TT2_OFF: begin
            countTick = 1'b0;
         end
         tt2_pkg::TT2_BAUD: begin
            if (ctrl_q[tt2_pkg::CNT_SEL_BIT]) begin
               countTick = countEdge;
            end else begin
               countTick = stateTick;
            end
         end
         default: begin
            if (ctrl_q[tt2_pkg::CNT_SEL_BIT]) begin
               countTick = countEdge;
            end else begin
               countTick = updateTick;
            end
         end
      endcase
   end

   // next count, capture pair and flag events
   always_comb begin
      count_d   = count;
      cap_d     = capture;
      wrapEvent = 1'b0;
      extSet    = 1'b0;
      extToggle = 1'b0;
      case (mode)
         tt2_pkg::TT2_CAPTURE: begin
            if (countTick) begin
               count_d   = count + tt2_pkg::COUNT_ONE;
               wrapEvent = (count == tt2_pkg::COUNT_MAX);
            end
         end
         tt2_pkg::TT2_BAUD: begin
            // forced reload on rollover, capture select ignored
            if (countTick) begin
               if (count == tt2_pkg::COUNT_MAX) begin
                  count_d   = capture;
                  wrapEvent = 1'b1;
               end else begin
                  count_d = count + tt2_pkg::COUNT_ONE;
               end
            end
         end
         tt2_pkg::TT2_RELOAD: begin
            if (downEn_q && !trigLevel) begin
               // down count: underflow at the capture pair reloads all ones
               if (countTick) begin
                  if (count == capture) begin
                     count_d   = tt2_pkg::COUNT_MAX;
                     wrapEvent = 1'b1;
                     extToggle = 1'b1;
                  end else begin
                     count_d = count - tt2_pkg::COUNT_ONE;
                  end
               end
            end else if (countTick && count == tt2_pkg::COUNT_MAX) begin
               count_d   = capture;
               wrapEvent = 1'b1;
               extToggle = downEn_q;
            end else if (countTick) begin
               count_d = count + tt2_pkg::COUNT_ONE;
            end
         end
         default: begin
            count_d = count;
         end
      endcase

      // trigger edges act even while stopped; in up/down mode the pin is direction
      if (trigEdge && ctrl_q[tt2_pkg::EXT_EN_BIT]) begin
         if (serialUse) begin
            extSet = 1'b1; // edge flags only, no reload
         end else if (ctrl_q[tt2_pkg::CAP_SEL_BIT]) begin
            cap_d  = count;
            extSet = 1'b1;
         end else if (!downEn_q) begin
            count_d = capture;
            extSet  = 1'b1;
         end
      end
   end

   assign flagOverflow = wrapEvent && !serialUse;

   // software write mask for the control register, byte or single bit
   always_comb begin
      wrMask = tt2_pkg::BYTE_ZERO;
      wrVal  = tt2_pkg::BYTE_ZERO;
      if (regWr && regAddr == tt2_pkg::CTRL_ADDR) begin
         wrMask = ~tt2_pkg::BYTE_ZERO;
         wrVal  = regWrData;
      end else if (bitWr) begin
         wrMask = tt2_pkg::BIT_ONE << bitIndex;
         wrVal  = bitValue ? wrMask : tt2_pkg::BYTE_ZERO;
      end
   end

   // hardware set is applied after the write so an event is never lost
   always_comb begin
      ctrl_d = (ctrl_q & ~wrMask) | (wrVal & wrMask);
      if (extToggle) begin
         ctrl_d[tt2_pkg::EXT_FLAG_BIT] = ~ctrl_d[tt2_pkg::EXT_FLAG_BIT];
      end
      if (extSet) begin
         ctrl_d[tt2_pkg::EXT_FLAG_BIT] = 1'b1;
      end
      if (flagOverflow) begin
         ctrl_d[tt2_pkg::OVF_FLAG_BIT] = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         ctrl_q <= tt2_pkg::CTRL_RESET;
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   always_comb begin
      downEn_d = downEn_q;
      if (regWr && regAddr == tt2_pkg::MODE_ADDR) begin
         downEn_d = regWrData[tt2_pkg::DOWN_EN_BIT];
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         downEn_q <= tt2_pkg::MODE_RESET[tt2_pkg::DOWN_EN_BIT];
      end else begin
         downEn_q <= downEn_d;
      end
   end

   // count halves; a software write to a half wins over the hardware update
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         countLow_q  <= tt2_pkg::BYTE_ZERO;
         countHigh_q <= tt2_pkg::BYTE_ZERO;
      end else begin
         if (regWr && regAddr == tt2_pkg::CNT_LOW_ADDR) begin
            countLow_q <= regWrData;
         end else begin
            countLow_q <= count_d[7:0];
         end
         if (regWr && regAddr == tt2_pkg::CNT_HIGH_ADDR) begin
            countHigh_q <= regWrData;
         end else begin
            countHigh_q <= count_d[15:8];
         end
      end
   end

   // capture pair; a hardware capture that changes the pair wins over a software write
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         capLow_q  <= tt2_pkg::BYTE_ZERO;
         capHigh_q <= tt2_pkg::BYTE_ZERO;
      end else if (cap_d != capture) begin
         capLow_q  <= cap_d[7:0];
         capHigh_q <= cap_d[15:8];
      end else begin
         if (regWr && regAddr == tt2_pkg::CAP_LOW_ADDR) begin
            capLow_q <= regWrData;
         end
         if (regWr && regAddr == tt2_pkg::CAP_HIGH_ADDR) begin
            capHigh_q <= regWrData;
         end
      end
   end

   // read data stand for exactly the cycle after the strobe
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         rdData_q <= tt2_pkg::BYTE_ZERO;
      end else if (!regRd) begin
         rdData_q <= tt2_pkg::BYTE_ZERO;
      end else if (regAddr == tt2_pkg::CTRL_ADDR) begin
         rdData_q <= ctrl_q;
      end else if (regAddr == tt2_pkg::MODE_ADDR) begin
         rdData_q <= {7'h00, downEn_q};
      end else if (regAddr == tt2_pkg::CNT_LOW_ADDR) begin
         rdData_q <= countLow_q;
      end else if (regAddr == tt2_pkg::CNT_HIGH_ADDR) begin
         rdData_q <= countHigh_q;
      end else if (regAddr == tt2_pkg::CAP_LOW_ADDR) begin
         rdData_q <= capLow_q;
      end else if (regAddr == tt2_pkg::CAP_HIGH_ADDR) begin
         rdData_q <= capHigh_q;
      end else begin
         rdData_q <= tt2_pkg::BYTE_ZERO;
      end
   end

   // interrupt request level; edge flag masked in up/down mode
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= timerIntEnable &&
                  (ctrl_q[tt2_pkg::OVF_FLAG_BIT] ||
                   (ctrl_q[tt2_pkg::EXT_FLAG_BIT] && !downEn_q));
      end
   end

   // serial clock routing only matters in serial modes 1 and 3
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         rxClk_q    <= 1'b0;
         txClk_q    <= 1'b0;
         ovfPulse_q <= 1'b0;
      end else begin
         ovfPulse_q <= wrapEvent;
         if (serialMode == tt2_pkg::SER_MODE1 || serialMode == tt2_pkg::SER_MODE3) begin
            rxClk_q <= ctrl_q[tt2_pkg::RX_SEL_BIT] ? wrapEvent : otherTimerOvf;
            txClk_q <= ctrl_q[tt2_pkg::TX_SEL_BIT] ? wrapEvent : otherTimerOvf;
         end else begin
            rxClk_q <= 1'b0;
            txClk_q <= 1'b0;
         end
      end
   end

   assign regRdData     = rdData_q;
   assign timerIrq      = irq_q;
   assign rxClkPulse    = rxClk_q;
   assign txClkPulse    = txClk_q;
   assign overflowPulse = ovfPulse_q;

endmodule

// [test/tt2_core_props.sv]
// concurrent checks on the timer two core ports
module tt2_core_props (
   // clock and reset
   input wire logic       mclk,
   input wire logic       rst_b,
   // register port
   input wire logic [7:0] regAddr,
   input wire logic       regWr,
   input wire logic       regRd,
   input wire logic [7:0] regRdData,
   input wire logic       bitWr,
   // system side
   input wire logic       timerIntEnable,
   input wire logic [1:0] serialMode,
   input wire logic       otherTimerOvf,
   input wire logic       timerIrq,
   input wire logic       rxClkPulse,
   input wire logic       txClkPulse,
   input wire logic       overflowPulse
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);

   sequence rdHole;
      regRd && (regAddr < tt2_pkg::CTRL_ADDR || regAddr > tt2_pkg::CAP_HIGH_ADDR);
   endsequence
   sequence rdMode;
      regRd && regAddr == tt2_pkg::MODE_ADDR;
   endsequence

   rd_idle_zero_a: assert property (!$past(regRd) |-> regRdData == 8'h00)
      else $error("read data not zero outside a read");
   rd_hole_a: assert property (rdHole |=> regRdData == 8'h00)
      else $error("unmapped read gave nonzero data");
   rd_mode_a: assert property (rdMode |=> regRdData[7:1] == 7'h00)
      else $error("mode register reserved bits nonzero");
   irq_gate_a: assert property (!timerIntEnable |=> !timerIrq)
      else $error("interrupt raised while disabled");
   // software writes are the only way a raised request may go away
   // the registered request follows a write one cycle late, so look one cycle back
   irq_hold_a: assert property (
      timerIrq && timerIntEnable && !$past(regWr) && !$past(bitWr) |=> timerIrq)
      else $error("interrupt dropped without a clear");
   ovf_single_a: assert property (overflowPulse |=> !overflowPulse)
      else $error("overflow pulse longer than one cycle");
   tx_route_a: assert property (txClkPulse |->
      $past(serialMode[0]) && (overflowPulse || $past(otherTimerOvf)))
      else $error("transmit clock pulse without a source");
   rx_route_a: assert property (rxClkPulse |->
      $past(serialMode[0]) && (overflowPulse || $past(otherTimerOvf)))
      else $error("receive clock pulse without a source");
endmodule

// [test/tt2_pin_model.sv]
// behavioural source for the external count and trigger pins
module tt2_pin_model (
   // clock
   input wire logic mclk,
   // pins
   output logic     countPin,
   output logic     trigPin
);
   timeunit 1ns;
   timeprecision 1ps;

   // port pins idle high, as a pulled-up line would
   initial begin
      countPin = 1'b1;
      trigPin = 1'b1;
   end

   // one falling edge; hold of 12 or more keeps each level for a full machine cycle
   task automatic fall(input bit trig, input int hold);
      if (trig) trigPin <= 1'b0;
      else countPin <= 1'b0;
      repeat (hold) @(posedge mclk);
      if (trig) trigPin <= 1'b1;
      else countPin <= 1'b1;
      repeat (hold) @(posedge mclk);
   endtask

   // park one pin at a level, used as count direction in up/down counting
   task automatic setLevel(input bit trig, input bit v);
      if (trig) trigPin <= v;
      else countPin <= v;
   endtask
endmodule

// [test/tt2_core_tb.sv]
// self-checking bench for the timer two core
module tt2_core_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] CTL = tt2_pkg::CTRL_ADDR;
   localparam logic [7:0] MOD = tt2_pkg::MODE_ADDR;
   localparam logic [7:0] CLO = tt2_pkg::CNT_LOW_ADDR;
   localparam logic [7:0] CHI = tt2_pkg::CNT_HIGH_ADDR;
   localparam logic [7:0] PLO = tt2_pkg::CAP_LOW_ADDR;
   localparam logic [7:0] PHI = tt2_pkg::CAP_HIGH_ADDR;
   logic       mclk, rst_b, regWr, regRd, bitWr, bitValue, timerIntEnable, otherTimerOvf;
   logic [7:0] regAddr, regWrData, regRdData;
   logic [2:0] bitIndex;
   logic [1:0] serialMode;
   logic       countPin, trigPin, timerIrq, rxClkPulse, txClkPulse, overflowPulse;
   int         failures, n_tests, k;

   tt2_core uut (.mclk, .rst_b, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
      .bitWr, .bitIndex, .bitValue, .countPin, .trigPin, .timerIntEnable, .serialMode,
      .otherTimerOvf, .timerIrq, .rxClkPulse, .txClkPulse, .overflowPulse);
   tt2_pin_model pins (.mclk, .countPin, .trigPin);

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic conclude;
      $display("checks %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask

   task automatic bw(input logic [2:0] i, input logic v);
      @(posedge mclk);
      bitWr <= 1'b1;
      bitIndex <= i;
      bitValue <= v;
      @(posedge mclk);
      bitWr <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe edge
   task automatic rc(input logic [7:0] a, input logic [7:0] e, input string n);
      @(posedge mclk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge mclk);
      regRd <= 1'b0;
      #1 chk(n, e, regRdData);
   endtask

   task automatic waitOvf(output int c);
      c = 0;
      do begin
         @(posedge mclk);
         #1 c++;
      end while (overflowPulse !== 1'b1 && c < 40);
      if (overflowPulse !== 1'b1) begin
         failures++;
         $display("unexpected overflowPulse: expected 1 seen 0");
         conclude();
      end
   endtask

   task automatic irqAfter(input logic e);
      repeat (3) @(posedge mclk);
      #1 chk("timerIrq", {7'h00, e}, {7'h00, timerIrq});
   endtask

   initial begin
      failures = 0;
      n_tests = 0;
      rst_b = 1'b0;
      regWr = 1'b0;
      regRd = 1'b0;
      bitWr = 1'b0;
      bitValue = 1'b0;
      bitIndex = 3'h0;
      regAddr = 8'h00;
      regWrData = 8'h00;
      timerIntEnable = 1'b0;
      otherTimerOvf = 1'b0;
      serialMode = 2'h0;
      repeat (12) @(posedge mclk);
      rst_b <= 1'b1;
      for (int a = 8'hC8; a <= 8'hCD; a++) rc(a[7:0], 8'h00, "reset value");
      wr(8'hFF, 8'hA5);
      rc(8'hFF, 8'h00, "unmapped");
      wr(MOD, 8'hFF);
      rc(MOD, 8'h01, "mode");
      wr(MOD, 8'h00);
      // exactly twelve running clocks give exactly one carry step
      wr(CLO, 8'hFF);
      wr(CTL, 8'h05);
      repeat (10) @(posedge mclk);
      wr(CTL, 8'h01);
      repeat (30) @(posedge mclk);
      rc(CLO, 8'h00, "count low");
      rc(CHI, 8'h01, "count high");
      // plain capture-mode timer wraps and flags
      wr(CLO, 8'hFF);
      wr(CHI, 8'hFF);
      wr(CTL, 8'h05);
      waitOvf(k);
      rc(CLO, 8'h00, "wrapped low");
      rc(CHI, 8'h00, "wrapped high");
      rc(CTL, 8'h85, "control");
      bw(3'h2, 1'b0);
      rc(CTL, 8'h81, "control");
      timerIntEnable <= 1'b1;
      irqAfter(1'b1);
      bw(3'h7, 1'b0);
      irqAfter(1'b0);
      // auto-reload from the capture pair
      wr(PLO, 8'h34);
      wr(PHI, 8'h12);
      wr(CLO, 8'hFF);
      wr(CHI, 8'hFF);
      wr(CTL, 8'h04);
      waitOvf(k);
      rc(CLO, 8'h34, "reload low");
      rc(CHI, 8'h12, "reload high");
      rc(CTL, 8'h84, "control");
      wr(CTL, 8'h00);
      // baud generator ignores the capture select and never flags
      serialMode <= 2'h1;
      wr(PLO, 8'hFE);
      wr(PHI, 8'hFF);
      wr(CLO, 8'hFE);
      wr(CHI, 8'hFF);
      wr(CTL, 8'h35);
      waitOvf(k);
      chk("txClkPulse", 8'h01, {7'h00, txClkPulse});
      chk("rxClkPulse", 8'h01, {7'h00, rxClkPulse});
      waitOvf(k);
      chk("baud period", 8'h04, k[7:0]);
      rc(CTL, 8'h35, "control");
      wr(CTL, 8'h25);
      waitOvf(k);
      chk("txClkPulse", 8'h00, {7'h00, txClkPulse});
      chk("rxClkPulse", 8'h01, {7'h00, rxClkPulse});
      // with transmit select clear the other timer's overflow is the transmit clock
      @(posedge mclk);
      otherTimerOvf <= 1'b1;
      @(posedge mclk);
      otherTimerOvf <= 1'b0;
      #1 chk("txClkPulse", 8'h01, {7'h00, txClkPulse});
      wr(CTL, 8'h00);
      serialMode <= 2'h0;
      // counter function at the highest rate, then a slow edge
      wr(CLO, 8'h00);
      wr(CHI, 8'h00);
      wr(CTL, 8'h06);
      repeat (3) pins.fall(1'b0, 12);
      pins.fall(1'b0, 30);
      repeat (24) @(posedge mclk);
      rc(CLO, 8'h04, "event count");
      wr(CTL, 8'h00);
      // trigger capture, interrupt blocked by down counting
      wr(CLO, 8'h3C);
      wr(CHI, 8'h5A);
      wr(CTL, 8'h09);
      pins.fall(1'b1, 12);
      rc(PLO, 8'h3C, "capture low");
      rc(PHI, 8'h5A, "capture high");
      rc(CTL, 8'h49, "control");
      wr(MOD, 8'h01);
      irqAfter(1'b0);
      wr(MOD, 8'h00);
      irqAfter(1'b1);
      wr(CTL, 8'h01);
      wr(CLO, 8'h11);
      pins.fall(1'b1, 12);
      rc(PLO, 8'h3C, "capture low");
      rc(CTL, 8'h01, "control");
      // up/down counting: a low trigger pin counts down to the capture pair
      wr(MOD, 8'h01);
      pins.setLevel(1'b1, 1'b0);
      repeat (24) @(posedge mclk);
      wr(CLO, 8'h3D);
      wr(CHI, 8'h5A);
      wr(CTL, 8'h04);
      waitOvf(k);
      rc(CLO, 8'hFF, "underflow low");
      rc(CHI, 8'hFF, "underflow high");
      rc(CTL, 8'hC4, "control");
      wr(CTL, 8'h00);
      wr(MOD, 8'h00);
      pins.setLevel(1'b1, 1'b1);
      conclude();
   end
endmodule

bind tt2_core tt2_core_props chk (.mclk, .rst_b, .regAddr, .regWr, .regRd, .regRdData,
   .bitWr, .timerIntEnable, .serialMode, .otherTimerOvf, .timerIrq, .rxClkPulse,
   .txClkPulse, .overflowPulse);
